// file: rtl/csg_top.sv
// How it works
// [R1] Core register writes cross via a synchronizer before taking effect.
// [R2] Bus-side registers read and write directly, no crossing delay.
// [R3] Counter register reads cross from the core domain before returning.
// [R4] Crossing always happens, even with core and bus on one clock.
// [R5] Each synchronized register has its own synchronizer and pending flag.
// [R6] Read and write crossings of the counter share one pending flag.
// [R7] Writes may be guarded; the event flag register is never guarded.
// [R8] Debugger writes bypass the write guard.
// [R9] Secure peripheral: non-secure access ignored, reads zero, error raised.
// [R10] Pending flag sets on issue and clears once transfer completes.
`include "csg_params.svh"
`timescale 1ns/1ns
`default_nettype none
module csg_top (
    input  wire logic                  clk_sys_i,
    input  wire logic                  srst_i,
    input  wire logic                  acc_req_i,
    input  wire logic                  acc_write_i,
    input  wire logic [`CSG_AW-1:0]    acc_addr_i,
    input  wire logic [`CSG_DW-1:0]    acc_wdata_i,
    input  wire logic                  acc_debug_i,
    input  wire logic                  acc_secure_i,
    input  wire logic                  periph_secure_i,
    input  wire logic                  guard_on_i,
    input  wire logic [`CSG_DW-1:0]    core_event_i,
    input  wire logic                  core_count_en_i,
    output logic                       acc_ack_o,
    output logic [`CSG_DW-1:0]         acc_rdata_o,
    output logic                       guard_err_o,
    output logic [`CSG_NPEND-1:0]      crossing_pending_flags_o,
    output logic [`CSG_DW-1:0]         bus_ctrl_o,
    output logic [`CSG_DW-1:0]         event_flags_o,
    output logic [`CSG_DW-1:0]         core_cfg_o,
    output logic [`CSG_DW-1:0]         core_count_o
);
    csg_pkg::csg_state_t       state_r, state_nxt;
    logic                      lat_wr_r, lat_wr_nxt;
    logic [`CSG_AW-1:0]        lat_addr_r, lat_addr_nxt;
    logic [`CSG_DW-1:0]        lat_data_r, lat_data_nxt;
    logic                      lat_blk_r, lat_blk_nxt;
    logic                      lat_grd_r, lat_grd_nxt;
    logic                      lat_dbg_r, lat_dbg_nxt;
    logic                      ack_r, ack_nxt;
    logic                      err_r, err_nxt;
    logic [`CSG_DW-1:0]        rdata_r, rdata_nxt;
    logic [`CSG_DW-1:0]        ctrl_r, ctrl_nxt;
    logic [`CSG_DW-1:0]        evf_r, evf_nxt;
    logic [`CSG_DW-1:0]        shadow_r, shadow_nxt;
    logic [`CSG_NPEND-1:0]     pend_r, pend_nxt;
    logic [`CSG_DW-1:0]        core_cfg_r, core_cfg_nxt;
    logic [`CSG_DW-1:0]        core_cnt_r, core_cnt_nxt;
    logic                      cfg_start, cnt_start, rq_start;
    logic                      cfg_busy, cnt_busy, rq_busy, bk_busy;
    logic                      cfg_valid, cnt_valid, rq_valid, bk_valid;
    logic [`CSG_DW-1:0]        cfg_data, cnt_data, bk_data;
    logic                      guarded;

    // ============================================================
    // Crossings: one synchronizer for the configuration write, three for the counter (write, read request, read return)
    // [R4] Unconditional crossing, even on a shared clock
    csg_xfer #(.W(`CSG_DW)) u_cfg_wr (
        .clk_sys_i (clk_sys_i), .srst_i (srst_i), .start_i (cfg_start), .data_i (shadow_nxt),
        .busy_o (cfg_busy), .valid_o (cfg_valid), .data_o (cfg_data));
    csg_xfer #(.W(`CSG_DW)) u_cnt_wr (
        .clk_sys_i (clk_sys_i), .srst_i (srst_i), .start_i (cnt_start), .data_i (lat_data_r),
        .busy_o (cnt_busy), .valid_o (cnt_valid), .data_o (cnt_data));
    csg_xfer #(.W(1)) u_cnt_rq (
        .clk_sys_i (clk_sys_i), .srst_i (srst_i), .start_i (rq_start), .data_i (`CSG_ONE_BIT),
        .busy_o (rq_busy), .valid_o (rq_valid), .data_o ());
    // [R3] Core answers a read request by sending its counter back
    csg_xfer #(.W(`CSG_DW)) u_cnt_bk (
        .clk_sys_i (clk_sys_i), .srst_i (srst_i), .start_i (rq_valid), .data_i (core_cnt_r),
        .busy_o (bk_busy), .valid_o (bk_valid), .data_o (bk_data));

    // ============================================================
    // Bus-side access sequencer
    always_comb begin
        state_nxt    = state_r;
        lat_wr_nxt   = lat_wr_r;
        lat_addr_nxt = lat_addr_r;
        lat_data_nxt = lat_data_r;
        lat_blk_nxt  = lat_blk_r;
        lat_grd_nxt  = lat_grd_r;
        lat_dbg_nxt  = lat_dbg_r;
        ack_nxt      = 1'h0;
        err_nxt      = 1'h0;
        rdata_nxt    = rdata_r;
        ctrl_nxt     = ctrl_r;
        evf_nxt      = evf_r;
        shadow_nxt   = shadow_r;
        cfg_start    = 1'h0;
        cnt_start    = 1'h0;
        rq_start     = 1'h0;
        // [R7] Guard spares the event flag register
        guarded = lat_wr_r && lat_grd_r && (lat_addr_r != `CSG_REG_EVF);
        case (state_r)
            csg_pkg::CSG_IDLE: begin
                // Attributes are caught with the request so they cannot shift mid-access
                if (acc_req_i) begin
                    lat_wr_nxt   = acc_write_i;
                    lat_addr_nxt = acc_addr_i;
                    lat_data_nxt = acc_wdata_i;
                    lat_blk_nxt  = periph_secure_i && !acc_secure_i;
                    lat_grd_nxt  = guard_on_i;
                    lat_dbg_nxt  = acc_debug_i;
                    state_nxt    = csg_pkg::CSG_EXEC;
                end
            end
            csg_pkg::CSG_EXEC: begin
                // [R9] Discard non-secure access to a secure peripheral
                if (lat_blk_r) begin
                    ack_nxt   = 1'h1;
                    err_nxt   = 1'h1;
                    rdata_nxt = `CSG_RST_BYTE;
                    state_nxt = csg_pkg::CSG_IDLE;
                // [R8] Debugger writes skip the guard
                end else if (guarded && !lat_dbg_r) begin
                    ack_nxt   = 1'h1;
                    err_nxt   = 1'h1;
                    state_nxt = csg_pkg::CSG_IDLE;
                end else begin
                    case (lat_addr_r)
                        // [R2] Bus-side registers answer at once
                        `CSG_REG_CTRL: begin
                            if (lat_wr_r) begin
                                ctrl_nxt = lat_data_r;
                            end else begin
                                rdata_nxt = ctrl_r;
                            end
                            ack_nxt   = 1'h1;
                            state_nxt = csg_pkg::CSG_IDLE;
                        end
                        `CSG_REG_EVF: begin
                            if (lat_wr_r) begin
                                evf_nxt = evf_r & ~lat_data_r;
                            end else begin
                                rdata_nxt = evf_r;
                            end
                            ack_nxt   = 1'h1;
                            state_nxt = csg_pkg::CSG_IDLE;
                        end
                        // [R1] Configuration write is posted through its synchronizer
                        `CSG_REG_CFG: begin
                            if (!lat_wr_r) begin
                                rdata_nxt = shadow_r;
                                ack_nxt   = 1'h1;
                                state_nxt = csg_pkg::CSG_IDLE;
                            end else if (!cfg_busy) begin
                                shadow_nxt = lat_data_r;
                                cfg_start  = 1'h1;
                                ack_nxt    = 1'h1;
                                state_nxt  = csg_pkg::CSG_IDLE;
                            end
                        end
                        default: begin
                            // [R1] Counter write waits for its own synchronizer
                            if (lat_wr_r) begin
                                if (!cnt_busy) begin
                                    cnt_start = 1'h1;
                                    ack_nxt   = 1'h1;
                                    state_nxt = csg_pkg::CSG_IDLE;
                                end
                            // [R3] Counter read goes through the core domain
                            end else if (!rq_busy && !bk_busy) begin
                                rq_start  = 1'h1;
                                state_nxt = csg_pkg::CSG_RDWAIT;
                            end
                        end
                    endcase
                end
            end
            csg_pkg::CSG_RDWAIT: begin
                if (bk_valid) begin
                    rdata_nxt = bk_data;
                    ack_nxt   = 1'h1;
                    state_nxt = csg_pkg::CSG_IDLE;
                end
            end
            default: begin
                state_nxt = csg_pkg::CSG_IDLE;
            end
        endcase
        // A core event in the clearing cycle survives the clear
        evf_nxt = evf_nxt | core_event_i;
        // [R5] One pending flag per synchronized register
        // [R6] Counter read and write share one flag
        // [R10] Flags follow synchronizer busy, set at issue, clear at return
        pend_nxt = `CSG_RST_PEND;
        pend_nxt[`CSG_PEND_CFG] = cfg_busy;
        pend_nxt[`CSG_PEND_CNT] = cnt_busy || rq_busy || bk_busy || (state_r == csg_pkg::CSG_RDWAIT);
    end

    // ============================================================
    // Core-domain registers, loaded by synchronizer output; the counter also counts up on core_count_en_i
    always_comb begin
        core_cfg_nxt = cfg_valid ? cfg_data : core_cfg_r;
        core_cnt_nxt = core_cnt_r;
        if (cnt_valid) begin
            core_cnt_nxt = cnt_data;
        end else if (core_count_en_i) begin
            core_cnt_nxt = core_cnt_r + `CSG_DW'(1);
        end
    end

    // ============================================================
    // State registers
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_r    <= csg_pkg::CSG_IDLE;
            lat_wr_r   <= 1'h0;
            lat_addr_r <= `CSG_REG_CTRL;
            lat_data_r <= `CSG_RST_BYTE;
            lat_blk_r  <= 1'h0;
            lat_grd_r  <= 1'h0;
            lat_dbg_r  <= 1'h0;
            ack_r      <= 1'h0;
            err_r      <= 1'h0;
            rdata_r    <= `CSG_RST_BYTE;
            ctrl_r     <= `CSG_RST_BYTE;
            evf_r      <= `CSG_RST_BYTE;
            shadow_r   <= `CSG_RST_BYTE;
            pend_r     <= `CSG_RST_PEND;
            core_cfg_r <= `CSG_RST_BYTE;
            core_cnt_r <= `CSG_RST_BYTE;
        end else begin
            state_r    <= state_nxt;
            lat_wr_r   <= lat_wr_nxt;
            lat_addr_r <= lat_addr_nxt;
            lat_data_r <= lat_data_nxt;
            lat_blk_r  <= lat_blk_nxt;
            lat_grd_r  <= lat_grd_nxt;
            lat_dbg_r  <= lat_dbg_nxt;
            ack_r      <= ack_nxt;
            err_r      <= err_nxt;
            rdata_r    <= rdata_nxt;
            ctrl_r     <= ctrl_nxt;
            evf_r      <= evf_nxt;
            shadow_r   <= shadow_nxt;
            pend_r     <= pend_nxt;
            core_cfg_r <= core_cfg_nxt;
            core_cnt_r <= core_cnt_nxt;
        end
    end

    assign acc_ack_o                = ack_r;
    assign acc_rdata_o              = rdata_r;
    assign guard_err_o              = err_r;
    assign crossing_pending_flags_o = pend_r;
    assign bus_ctrl_o               = ctrl_r;
    assign event_flags_o            = evf_r;
    assign core_cfg_o               = core_cfg_r;
    assign core_count_o             = core_cnt_r;

    // ============================================================
    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    a_sec_read_zero: assert property ( // [R9]
        (state_r == csg_pkg::CSG_EXEC && lat_blk_r) |=> acc_ack_o && guard_err_o && acc_rdata_o == `CSG_RST_BYTE)
        else $error("secure discard did not answer zero with error");
    a_sec_write_drop: assert property ( // [R9]
        (state_r == csg_pkg::CSG_EXEC && lat_blk_r && lat_wr_r) |=> bus_ctrl_o == $past(bus_ctrl_o))
        else $error("non-secure write changed a register");
    a_guard_blocks_write: assert property ( // [R7]
        (state_r == csg_pkg::CSG_EXEC && !lat_blk_r && guarded && !lat_dbg_r)
        |=> guard_err_o && bus_ctrl_o == $past(bus_ctrl_o))
        else $error("guarded write was not refused");
    a_evf_never_guarded: assert property ( // [R7]
        (state_r == csg_pkg::CSG_EXEC && !lat_blk_r && lat_wr_r && lat_grd_r
         && lat_addr_r == `CSG_REG_EVF && core_event_i == `CSG_RST_BYTE)
        |=> (event_flags_o & $past(lat_data_r)) == `CSG_RST_BYTE && !guard_err_o)
        else $error("event flag clear was blocked");
    a_debug_bypass: assert property ( // [R8]
        (state_r == csg_pkg::CSG_EXEC && !lat_blk_r && lat_wr_r && lat_dbg_r && lat_addr_r == `CSG_REG_CTRL)
        |=> bus_ctrl_o == $past(lat_data_r) && !guard_err_o)
        else $error("debugger write did not land");
    a_direct_two_cycles: assert property ( // [R2]
        (state_r == csg_pkg::CSG_IDLE && acc_req_i && acc_addr_i == `CSG_REG_CTRL) |=> !acc_ack_o ##1 acc_ack_o)
        else $error("bus-side access not answered in two cycles");
    a_cfg_crossing_delay: assert property ( // [R1]
        cfg_start |=> !cfg_valid [*2] ##[1:3] cfg_valid ##1 core_cfg_o == $past(cfg_data))
        else $error("configuration write skipped its synchronizer");
    a_cfg_pend_set: assert property ( // [R10]
        cfg_start |-> ##2 crossing_pending_flags_o[`CSG_PEND_CFG] ##[1:8] !crossing_pending_flags_o[`CSG_PEND_CFG])
        else $error("configuration pending flag wrong");
    a_cnt_shared_flag: assert property ( // [R6]
        (rq_start && !cfg_busy)
        |-> ##2 crossing_pending_flags_o[`CSG_PEND_CNT] && !crossing_pending_flags_o[`CSG_PEND_CFG])
        else $error("counter read pending not on shared flag");
    a_read_sync_time: assert property ( // [R3]
        rq_start |=> (state_r == csg_pkg::CSG_RDWAIT) ##[4:12] acc_ack_o)
        else $error("synchronized read not answered in time");
endmodule // csg_top
`default_nettype wire

// file: rtl/csg_params.svh
`ifndef CSG_PARAMS_SVH
`define CSG_PARAMS_SVH

// ============================================================
// Widths
`define CSG_DW        8
`define CSG_AW        2
`define CSG_NPEND     2

// ============================================================
// Register indices on the access port
`define CSG_REG_CTRL  2'h0
`define CSG_REG_EVF   2'h1
`define CSG_REG_CFG   2'h2
`define CSG_REG_CNT   2'h3

// ============================================================
// Pending-crossing flag positions and reset values
`define CSG_PEND_CFG  0
`define CSG_PEND_CNT  1
`define CSG_RST_BYTE  8'h00
`define CSG_RST_PEND  2'h0
`define CSG_ONE_BIT   1'h1

`endif

// file: rtl/csg_pkg.sv
package csg_pkg;
    // Bus-side access sequencer states
    typedef enum logic [1:0] {
        CSG_IDLE,
        CSG_EXEC,
        CSG_RDWAIT
    } csg_state_t;
endpackage

// file: rtl/csg_xfer.sv
`timescale 1ns/1ns
`default_nettype none
// Toggle handshake crossing: one word at a time, busy until the ack returns
module csg_xfer #(
    parameter int W = 8
) (
    input  wire logic         clk_sys_i,
    input  wire logic         srst_i,
    input  wire logic         start_i,
    input  wire logic [W-1:0] data_i,
    output logic              busy_o,
    output logic              valid_o,
    output logic [W-1:0]      data_o
);
    logic         req_tgl_r, req_tgl_nxt;
    logic [W-1:0] hold_r, hold_nxt;
    logic         req_s1_r, req_s2_r, req_s3_r;
    logic         ack_s1_r, ack_s2_r;
    logic         valid_r, valid_nxt;
    logic [W-1:0] out_r, out_nxt;

    // ============================================================
    // Next state: source toggles, destination captures on toggle edge
    always_comb begin
        req_tgl_nxt = req_tgl_r;
        hold_nxt    = hold_r;
        if (start_i && !busy_o) begin
            req_tgl_nxt = ~req_tgl_r;
            hold_nxt    = data_i;
        end
        // Held word is stable for three cycles before capture, so no tearing
        valid_nxt = req_s2_r ^ req_s3_r;
        out_nxt   = valid_nxt ? hold_r : out_r;
    end

    // ============================================================
    // Registers; req_s1_r and ack_s1_r feed only their second stage
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            req_tgl_r <= 1'h0;
            hold_r    <= '0;
            req_s1_r  <= 1'h0;
            req_s2_r  <= 1'h0;
            req_s3_r  <= 1'h0;
            ack_s1_r  <= 1'h0;
            ack_s2_r  <= 1'h0;
            valid_r   <= 1'h0;
            out_r     <= '0;
        end else begin
            req_tgl_r <= req_tgl_nxt;
            hold_r    <= hold_nxt;
            req_s1_r  <= req_tgl_r;
            req_s2_r  <= req_s1_r;
            req_s3_r  <= req_s2_r;
            ack_s1_r  <= req_s3_r;
            ack_s2_r  <= ack_s1_r;
            valid_r   <= valid_nxt;
            out_r     <= out_nxt;
        end
    end

    assign busy_o  = req_tgl_r ^ ack_s2_r;
    assign valid_o = valid_r;
    assign data_o  = out_r;
endmodule // csg_xfer
`default_nettype wire

// file: testbench/csg_master.sv
`include "csg_params.svh"
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// Bus master model on the access port
module csg_master (
    input  wire logic               clk_sys_i,
    input  wire logic               acc_ack_i,
    input  wire logic [`CSG_DW-1:0] acc_rdata_i,
    input  wire logic               acc_err_i,
    output logic                    acc_req_o,
    output logic                    acc_write_o,
    output logic [`CSG_AW-1:0]      acc_addr_o,
    output logic [`CSG_DW-1:0]      acc_wdata_o,
    output logic                    acc_debug_o,
    output logic                    acc_secure_o
);
    // Idle master: no request, qualifiers all driven low
    initial begin
        acc_req_o    = 1'h0;
        acc_write_o  = 1'h0;
        acc_addr_o   = 2'h0;
        acc_wdata_o  = 8'h00;
        acc_debug_o  = 1'h0;
        acc_secure_o = 1'h0;
    end
    // One access; request dropped as soon as ack shows, so it is never taken twice
    task automatic access(input logic wr, input logic [`CSG_AW-1:0] ad, input logic [`CSG_DW-1:0] wd,
                          input logic dbg, input logic sec,
                          output logic [`CSG_DW-1:0] rd, output logic err, output logic [7:0] lat);
        int n;
        n   = 0;
        lat = 8'hFF;
        err = 1'h0;
        rd  = 8'h00;
        @(negedge clk_sys_i);
        acc_req_o    = 1'h1;
        acc_write_o  = wr;
        acc_addr_o   = ad;
        acc_wdata_o  = wd;
        acc_debug_o  = dbg;
        acc_secure_o = sec;
        while (n < 40) begin
            @(negedge clk_sys_i);
            n++;
            if (acc_ack_i === 1'h1) begin
                lat = n[7:0];
                rd  = acc_rdata_i;
                err = acc_err_i;
                break;
            end
        end
        // Released request, write, address and data lines do not keep their last value; debug and secure do
        acc_req_o   = 1'h0;
        acc_write_o = ~acc_write_o;
        acc_addr_o  = ~acc_addr_o;
        acc_wdata_o = ~acc_wdata_o;
    endtask
endmodule // csg_master
`default_nettype wire

// file: testbench/test_csg_top.sv
`include "csg_params.svh"
`timescale 1ns/1ns
`default_nettype none
module test_csg_top;
    logic                    clk_sys_i = 1'h0;
    logic                    srst_i = 1'h1;
    logic                    guard_on_i = 1'h0;
    logic                    periph_secure_i = 1'h0;
    logic [`CSG_DW-1:0]      core_event_i = 8'h00;
    logic                    core_count_en_i = 1'h0;
    wire logic               req, wr, dbg, sec, ack, err_o;
    wire logic [`CSG_AW-1:0] addr;
    wire logic [`CSG_DW-1:0] wdata, rdata, ctrl, evf, cfg, cnt;
    wire logic [`CSG_NPEND-1:0] pend;
    logic [`CSG_DW-1:0]      rd;
    logic [7:0]              lat;
    logic                    err;
    logic [`CSG_NPEND-1:0]   seen = 2'h0;
    logic                    seen_clr = 1'h0;
    int                      fails = 0;
    int                      checks = 0;
    always #4 clk_sys_i = ~clk_sys_i;
    // Remember any pending flag raised since the last clear
    always @(posedge clk_sys_i) seen <= (seen_clr ? 2'h0 : seen) | pend;
    csg_master i_csg_master (.clk_sys_i(clk_sys_i), .acc_ack_i(ack), .acc_rdata_i(rdata), .acc_err_i(err_o),
        .acc_req_o(req), .acc_write_o(wr), .acc_addr_o(addr), .acc_wdata_o(wdata), .acc_debug_o(dbg),
        .acc_secure_o(sec));
    csg_top i_csg_top (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .acc_req_i(req), .acc_write_i(wr),
        .acc_addr_i(addr), .acc_wdata_i(wdata), .acc_debug_i(dbg), .acc_secure_i(sec),
        .periph_secure_i(periph_secure_i), .guard_on_i(guard_on_i), .core_event_i(core_event_i),
        .core_count_en_i(core_count_en_i), .acc_ack_o(ack), .acc_rdata_o(rdata), .guard_err_o(err_o),
        .crossing_pending_flags_o(pend), .bus_ctrl_o(ctrl), .event_flags_o(evf), .core_cfg_o(cfg),
        .core_count_o(cnt));
    // ============================================================
    // Shared tasks
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // A lost ack ends the run, nothing after it is meaningful
    task automatic acc(input logic w, input logic [1:0] a, input logic [7:0] d, input logic g, input logic s);
        i_csg_master.access(w, a, d, g, s, rd, err, lat);
        if (lat === 8'hFF) begin
            fails++;
            $display("MISMATCH ack expected pulse seen none");
            close_out();
        end
    endtask
    // One process owns the record; scenarios only ask for a restart
    task automatic clr_seen();
        seen_clr = 1'h1;
        @(negedge clk_sys_i);
        seen_clr = 1'h0;
    endtask
    task automatic wait_clear();
        int n;
        n = 0;
        @(negedge clk_sys_i);
        while (pend !== 2'h0) begin
            @(negedge clk_sys_i);
            n++;
            if (n > 40) begin
                fails++;
                $display("MISMATCH pending expected 0 seen %b", pend);
                close_out();
            end
        end
    endtask
    // ============================================================
    // Scenarios
    task automatic t_reset();
        chk("ctrl", 8'h00, ctrl);
        chk("evf", 8'h00, evf);
        chk("cfg", 8'h00, cfg);
        chk("cnt", 8'h00, cnt);
        chk("pend", 8'h00, {6'h0, pend});
        $display("test reset done");
    endtask
    task automatic t_bus_side();
        acc(1'h1, `CSG_REG_CTRL, 8'hA5, 1'h0, 1'h1);
        chk("ctrl wr lat", 8'h02, lat);
        chk("ctrl", 8'hA5, ctrl);
        acc(1'h0, `CSG_REG_CTRL, 8'h00, 1'h0, 1'h1);
        chk("ctrl rd", 8'hA5, rd);
        chk("ctrl rd lat", 8'h02, lat);
        $display("test bus side done");
    endtask
    task automatic t_cfg();
        clr_seen();
        acc(1'h1, `CSG_REG_CFG, 8'h3C, 1'h0, 1'h1);
        chk("cfg at ack", 8'h00, cfg);
        wait_clear();
        chk("cfg", 8'h3C, cfg);
        chk("cfg pend", 8'h01, {6'h0, seen});
        acc(1'h0, `CSG_REG_CFG, 8'h00, 1'h0, 1'h1);
        chk("cfg rd", 8'h3C, rd);
        chk("cfg rd lat", 8'h02, lat);
        $display("test cfg done");
    endtask
    task automatic t_cnt();
        clr_seen();
        acc(1'h1, `CSG_REG_CNT, 8'h40, 1'h0, 1'h1);
        wait_clear();
        chk("cnt wr pend", 8'h02, {6'h0, seen});
        chk("cnt", 8'h40, cnt);
        core_count_en_i = 1'h1;
        repeat (5) @(negedge clk_sys_i);
        core_count_en_i = 1'h0;
        clr_seen();
        acc(1'h0, `CSG_REG_CNT, 8'h00, 1'h0, 1'h1);
        chk("cnt rd", 8'h45, rd);
        chk("cnt rd slow", 8'h01, {7'h0, lat >= 8'h0A});
        wait_clear();
        chk("cnt rd pend", 8'h02, {6'h0, seen});
        $display("test cnt done");
    endtask
    task automatic t_guard();
        guard_on_i = 1'h1;
        acc(1'h1, `CSG_REG_CTRL, 8'h5A, 1'h0, 1'h1);
        chk("guard err", 8'h01, {7'h0, err});
        chk("ctrl kept", 8'hA5, ctrl);
        acc(1'h1, `CSG_REG_CFG, 8'h11, 1'h0, 1'h1);
        wait_clear();
        chk("cfg kept", 8'h3C, cfg);
        acc(1'h1, `CSG_REG_CTRL, 8'h5A, 1'h1, 1'h1);
        chk("dbg err", 8'h00, {7'h0, err});
        chk("dbg ctrl", 8'h5A, ctrl);
        core_event_i = 8'h81;
        @(negedge clk_sys_i);
        core_event_i = 8'h00;
        repeat (2) @(negedge clk_sys_i);
        chk("evf set", 8'h81, evf);
        acc(1'h1, `CSG_REG_EVF, 8'h01, 1'h0, 1'h1);
        chk("evf err", 8'h00, {7'h0, err});
        chk("evf clr", 8'h80, evf);
        acc(1'h0, `CSG_REG_EVF, 8'h00, 1'h0, 1'h1);
        chk("evf rd", 8'h80, rd);
        guard_on_i = 1'h0;
        $display("test guard done");
    endtask
    task automatic t_secure();
        periph_secure_i = 1'h1;
        acc(1'h1, `CSG_REG_CTRL, 8'h00, 1'h0, 1'h0);
        chk("ns wr err", 8'h01, {7'h0, err});
        chk("ns wr ctrl", 8'h5A, ctrl);
        acc(1'h0, `CSG_REG_CTRL, 8'h00, 1'h0, 1'h0);
        chk("ns rd", 8'h00, rd);
        chk("ns rd err", 8'h01, {7'h0, err});
        acc(1'h0, `CSG_REG_CTRL, 8'h00, 1'h0, 1'h1);
        chk("s rd", 8'h5A, rd);
        chk("s rd err", 8'h00, {7'h0, err});
        periph_secure_i = 1'h0;
        $display("test secure done");
    endtask
    // ============================================================
    // Main sequence
    initial begin
        repeat (16) @(negedge clk_sys_i);
        srst_i = 1'h0;
        @(negedge clk_sys_i);
        t_reset();
        t_bus_side();
        t_cfg();
        t_cnt();
        t_guard();
        t_secure();
        close_out();
    end
endmodule // test_csg_top
`default_nettype wire
